// ---- drive_parameter_setup_consts.svh ----
`ifndef DRIVE_PARAMETER_SETUP_CONSTS_SVH
`define DRIVE_PARAMETER_SETUP_CONSTS_SVH

`define CLK_PERIOD_NS 10

// step pulse width, hard disk: one unit per group of seven codes
`define STEP_WIDTH_UNIT_NS 6800
`define STEP_WIDTH_UNIT_CYC (`STEP_WIDTH_UNIT_NS / `CLK_PERIOD_NS)
`define STEP_WIDTH_GROUP 7
`define STEP_WIDTH_MAX_UNITS 32

// step pulse width, floppy: roughly one microsecond per code
`define FLOPPY_WIDTH_UNIT_NS 1000
`define FLOPPY_WIDTH_UNIT_CYC (`FLOPPY_WIDTH_UNIT_NS / `CLK_PERIOD_NS)
`define FLOPPY_WIDTH_MIN_CODE 17

`define STEP_PERIOD_UNIT_US 50
`define STEP_PERIOD_UNIT_CYC (`STEP_PERIOD_UNIT_US * 1000 / `CLK_PERIOD_NS)
`define FIXED_PERIOD_NS 13000
`define FIXED_PERIOD_CYC (`FIXED_PERIOD_NS / `CLK_PERIOD_NS)
`define FLOPPY_INTERVAL_UNIT_MS 1
`define FLOPPY_INTERVAL_UNIT_CYC \
  (`FLOPPY_INTERVAL_UNIT_MS * 1000000 / `CLK_PERIOD_NS)
`define SEEK_TIMEOUT_MS 700
`define SEEK_TIMEOUT_CYC (`SEEK_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)

`define SET_PARAMS_OPCODE 8'hC2
`define CMD_BYTES 6
`define PARAM_BYTES 10
`define STEP_MODE_FIXED 8'h04
`define SEEK_NO_WAIT_BIT 6

// byte 9 first, byte 0 last
`define HD_DEFAULTS {8'h00, 8'h00, 8'h00, 8'h7F, 8'h98, 8'h00, 8'h03, \
  8'h00, 8'h3C, 8'h0B}
`define FLOPPY_DEFAULTS {8'h00, 8'h00, 8'h80, 8'h0B, 8'h00, 8'hCD, \
  8'h16, 8'h4F, 8'h07, 8'h02}

`define REG_CONTROL 8'h00
`define REG_SEEK 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STATUS 8'h0C
`define REG_IRQ_ENABLE 8'h10
`define REG_IRQ_CLEAR 8'h14
`define REG_PARAM_SEL 8'h18
`define REG_PARAM_DATA 8'h1C

`define SEEK_UNIT_LSB 0
`define SEEK_HEAD_LSB 4
`define SEEK_CYL_LSB 16

`define IRQ_LOADED 0
`define IRQ_REJECT 1
`define IRQ_SEEK_DONE 2
`define IRQ_TIMEOUT 3
`define IRQ_RANGE 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- drive_parameter_setup_pkg.sv ----
package drive_parameter_setup_pkg;

  typedef enum logic [1:0] {
    C_INIT = 2'h0,
    C_CMD = 2'h1,
    C_DATA = 2'h3
  } cmd_state_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_GAP = 2'h1,
    S_PULSE = 2'h3,
    S_WAIT = 2'h2
  } seek_state_t;

  typedef logic [9:0][7:0] param_set_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic cd_s1;
    logic cd_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic sc_s1;
    logic sc_s2;
    logic [1:0] sw_s1;
    logic [1:0] sw_s2;
    logic [1:0] init_cnt;
    cmd_state_t cmd_st;
    logic [3:0] byte_cnt;
    logic cmd_bad;
    logic [2:0] cmd_unit;
    param_set_t stage;
    logic [7:0][9:0][7:0] params;
    logic [1:0] floppy;
    logic host_ack;
    seek_state_t seek_st;
    logic [2:0] seek_unit;
    logic [3:0] seek_head;
    logic [7:0][9:0] cyl;
    logic [9:0] remaining;
    logic dir;
    logic step;
    logic [26:0] tmr;
    logic [26:0] tout;
    logic rwc;
    logic ext_heads;
    logic [6:0] param_sel;
    logic [4:0] irq_stat;
    logic [4:0] irq_en;
    logic irq;
    logic aw_full;
    logic [7:0] awaddr_q;
    logic w_full;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage : drive_parameter_setup_pkg

// ---- drive_parameter_setup.sv ----
// Operation
// - reset loads hard-disk defaults for every unit
// - command opcode C2, unit in byte 1
// - collect exactly ten data-phase parameter bytes
// - separate parameter set kept per unit
// - switches make units 0/1 floppy
// - hard-disk default bytes as listed
// - byte 0 step width, 6.8 us groups
// - byte 1 step gap, 50 us units
// - byte 2 mode 4 fixed 13 us
// - byte 3 highest head address limits heads
// - bytes 4/5 give maximum cylinder
// - byte 6 reduced write current cylinder
// - extended heads reuse reduce-current line
// - byte 7 bit 6 skips seek-complete wait
// - seek over 700 ms flags error
// - floppy default bytes as listed
// - floppy byte 1 interval in ms
`timescale 1ns/10ps
`include "drive_parameter_setup_consts.svh"

module drive_parameter_setup
  import drive_parameter_setup_pkg::*;
#(
  parameter int STEP_PERIOD_CYC = `STEP_PERIOD_UNIT_CYC,
  parameter int INTERVAL_CYC = `FLOPPY_INTERVAL_UNIT_CYC,
  parameter int TIMEOUT_CYC = `SEEK_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic host_req,
  input wire logic host_cd,
  input wire logic [7:0] host_data,
  output logic host_ack,
  input wire logic [1:0] floppy_switch,
  input wire logic seek_complete,
  output logic step,
  output logic step_dir,
  output logic reduce_write_current,
  output logic irq,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  state_t st;
  state_t next;

  logic take;
  logic wr_fire;
  logic seek_req;
  logic [4:0] set_ev;
  logic [4:0] clr;
  param_set_t cur_p;
  logic cur_flop;
  logic [2:0] req_unit;
  logic [3:0] req_head;
  logic [9:0] req_cyl;
  param_set_t req_p;
  logic req_flop;
  logic [9:0] max_cyl;
  logic head_ok;
  logic [31:0] rd_val;
  logic rd_err;

  function automatic logic [26:0] width_cyc(input logic [7:0] code,
                                            input logic flop);
    logic [5:0] units;
    units = 6'(code / 8'(`STEP_WIDTH_GROUP)) + 6'h01;
    if (units > 6'(`STEP_WIDTH_MAX_UNITS)) begin
      units = 6'(`STEP_WIDTH_MAX_UNITS);
    end
    if (flop) begin
      width_cyc = 27'((code < 8'(`FLOPPY_WIDTH_MIN_CODE) ?
        8'(`FLOPPY_WIDTH_MIN_CODE) : code) * `FLOPPY_WIDTH_UNIT_CYC);
    end else begin
      width_cyc = 27'(units * `STEP_WIDTH_UNIT_CYC);
    end
  endfunction : width_cyc

  function automatic logic [26:0] gap_cyc(input logic [7:0] code,
                                          input logic [7:0] mode,
                                          input logic flop,
                                          input int unit_cyc,
                                          input int ms_cyc);
    if (flop) begin
      // code 0 stands for 256 ms
      gap_cyc = 27'((code == 8'h00 ? 9'h100 : {1'h0, code}) * ms_cyc);
    end else if (mode == `STEP_MODE_FIXED) begin
      gap_cyc = 27'(`FIXED_PERIOD_CYC);
    end else begin
      gap_cyc = 27'((code == 8'h00 ? 8'h01 : code) * unit_cyc);
    end
  endfunction : gap_cyc

  always_comb begin
    next = st;
    set_ev = 5'h00;
    clr = 5'h00;
    seek_req = 1'b0;
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    cur_p = st.params[st.seek_unit];
    cur_flop = (st.seek_unit[2:1] == 2'h0) && st.floppy[st.seek_unit[0]];
    req_unit = st.wdata_q[`SEEK_UNIT_LSB +: 3];
    req_head = st.wdata_q[`SEEK_HEAD_LSB +: 4];
    req_cyl = st.wdata_q[`SEEK_CYL_LSB +: 10];
    req_p = st.params[req_unit];
    req_flop = (req_unit[2:1] == 2'h0) && st.floppy[req_unit[0]];

    // pin synchronisers
    next.req_s1 = host_req;
    next.req_s2 = st.req_s1;
    next.cd_s1 = host_cd;
    next.cd_s2 = st.cd_s1;
    next.dat_s1 = host_data;
    next.dat_s2 = st.dat_s1;
    next.sc_s1 = seek_complete;
    next.sc_s2 = st.sc_s1;
    next.sw_s1 = floppy_switch;
    next.sw_s2 = st.sw_s1;

    // four-phase byte handshake, held off until init is done
    take = st.req_s2 && !st.host_ack && st.cmd_st != C_INIT;
    if (take) begin
      next.host_ack = 1'b1;
    end else if (!st.req_s2) begin
      next.host_ack = 1'b0;
    end

    unique case (st.cmd_st)
      C_INIT: begin
        next.init_cnt = st.init_cnt + 2'h1;
        if (st.init_cnt == 2'h3) begin
          for (int u = 0; u < 2; u++) begin
            if (st.sw_s2[u]) begin
              next.params[u] = `FLOPPY_DEFAULTS;
            end
          end
          next.floppy = st.sw_s2;
          next.cmd_st = C_CMD;
        end
      end
      C_CMD: begin
        if (take && !st.cd_s2) begin
          set_ev[`IRQ_REJECT] = 1'b1;
        end else if (take) begin
          if (st.byte_cnt == 4'h0) begin
            next.cmd_bad = st.dat_s2 != `SET_PARAMS_OPCODE;
          end
          if (st.byte_cnt == 4'h1) begin
            next.cmd_unit = st.dat_s2[7:5];
          end
          next.byte_cnt = st.byte_cnt + 4'h1;
          if (st.byte_cnt == 4'(`CMD_BYTES - 1)) begin
            next.byte_cnt = 4'h0;
            if (st.cmd_bad) begin
              set_ev[`IRQ_REJECT] = 1'b1;
            end else begin
              next.cmd_st = C_DATA;
            end
          end
        end
      end
      C_DATA: begin
        if (take && st.cd_s2) begin
          // command byte mid-data: abort and restart the block
          set_ev[`IRQ_REJECT] = 1'b1;
          next.cmd_bad = st.dat_s2 != `SET_PARAMS_OPCODE;
          next.byte_cnt = 4'h1;
          next.cmd_st = C_CMD;
        end else if (take) begin
          next.stage[st.byte_cnt] = st.dat_s2;
          next.byte_cnt = st.byte_cnt + 4'h1;
          if (st.byte_cnt == 4'(`PARAM_BYTES - 1)) begin
            next.params[st.cmd_unit] = next.stage;
            set_ev[`IRQ_LOADED] = 1'b1;
            next.byte_cnt = 4'h0;
            next.cmd_st = C_CMD;
          end
        end
      end
      default: begin
        next.cmd_st = C_INIT;
      end
    endcase

    // register bus, write side
    if (awvalid && st.awready) begin
      next.aw_full = 1'b1;
      next.awaddr_q = {awaddr[7:2], 2'h0};
    end
    if (wvalid && st.wready) begin
      next.w_full = 1'b1;
      next.wdata_q = wdata;
      next.wstrb_q = wstrb;
    end
    if (st.bvalid && bready) begin
      next.bvalid = 1'b0;
      next.aw_full = 1'b0;
      next.w_full = 1'b0;
    end
    wr_fire = st.aw_full && st.w_full && !st.bvalid;
    if (wr_fire) begin
      next.bvalid = 1'b1;
      next.bresp = `RESP_OKAY;
      case (st.awaddr_q)
        `REG_CONTROL: begin
          if (st.wstrb_q[0]) begin
            next.ext_heads = st.wdata_q[0];
          end
        end
        `REG_SEEK: begin
          seek_req = st.wstrb_q == 4'hF;
        end
        `REG_IRQ_ENABLE: begin
          if (st.wstrb_q[0]) begin
            next.irq_en = st.wdata_q[4:0];
          end
        end
        `REG_IRQ_CLEAR: begin
          if (st.wstrb_q[0]) begin
            clr = st.wdata_q[4:0];
          end
        end
        `REG_PARAM_SEL: begin
          if (st.wstrb_q[0]) begin
            next.param_sel = st.wdata_q[6:0];
          end
        end
        `REG_STATUS, `REG_IRQ_STATUS, `REG_PARAM_DATA: begin
        end
        default: begin
          next.bresp = `RESP_SLVERR;
        end
      endcase
    end
    next.awready = !next.aw_full;
    next.wready = !next.w_full;

    // seek request, ignored while a seek runs
    max_cyl = req_flop ? {2'h0, req_p[2]} : {req_p[4][1:0], req_p[5]};
    head_ok = req_flop ? (req_head <= 4'h1) :
      (req_head <= req_p[3][3:0] && (st.ext_heads || !req_head[3]));
    if (seek_req && st.seek_st == S_IDLE) begin
      if (req_cyl > max_cyl || !head_ok) begin
        set_ev[`IRQ_RANGE] = 1'b1;
      end else begin
        next.seek_unit = req_unit;
        next.seek_head = req_head;
        next.dir = req_cyl > st.cyl[req_unit];
        next.remaining = (req_cyl > st.cyl[req_unit]) ?
          req_cyl - st.cyl[req_unit] : st.cyl[req_unit] - req_cyl;
        next.tmr = 27'h000_0001;
        next.tout = 27'h000_0000;
        next.seek_st = S_GAP;
      end
    end

    if (st.seek_st != S_IDLE) begin
      next.tout = st.tout + 27'h000_0001;
      if (st.tout >= 27'(TIMEOUT_CYC - 1)) begin
        next.seek_st = S_IDLE;
        next.step = 1'b0;
        set_ev[`IRQ_TIMEOUT] = 1'b1;
      end else begin
        unique case (st.seek_st)
          S_IDLE: begin
          end
          S_PULSE: begin
            if (st.tmr <= 27'h000_0001) begin
              next.step = 1'b0;
              next.cyl[st.seek_unit] = st.dir ?
                st.cyl[st.seek_unit] + 10'h001 :
                st.cyl[st.seek_unit] - 10'h001;
              next.remaining = st.remaining - 10'h001;
              next.tmr = gap_cyc(cur_p[1], cur_p[2], cur_flop,
                STEP_PERIOD_CYC, INTERVAL_CYC);
              next.seek_st = S_GAP;
            end else begin
              next.tmr = st.tmr - 27'h000_0001;
            end
          end
          S_GAP: begin
            if (st.tmr > 27'h000_0001) begin
              next.tmr = st.tmr - 27'h000_0001;
            end else if (st.remaining != 10'h000) begin
              next.step = 1'b1;
              next.tmr = width_cyc(cur_p[0], cur_flop);
              next.seek_st = S_PULSE;
            end else if (!cur_flop && !cur_p[7][`SEEK_NO_WAIT_BIT]) begin
              next.seek_st = S_WAIT;
            end else begin
              next.seek_st = S_IDLE;
              set_ev[`IRQ_SEEK_DONE] = 1'b1;
            end
          end
          S_WAIT: begin
            if (st.sc_s2) begin
              next.seek_st = S_IDLE;
              set_ev[`IRQ_SEEK_DONE] = 1'b1;
            end
          end
        endcase
      end
    end

    if (cur_flop) begin
      next.rwc = 1'b0;
    end else if (st.ext_heads && cur_p[3][3:0] > 4'h7) begin
      next.rwc = st.seek_head[3];
    end else begin
      next.rwc = cur_p[6] != 8'h00 &&
        st.cyl[st.seek_unit] >= {2'h0, cur_p[6]};
    end

    // sticky status: a new event beats a clear in the same cycle
    next.irq_stat = (st.irq_stat & ~clr) | set_ev;
    next.irq = |(next.irq_stat & next.irq_en);

    // register bus, read side
    case ({araddr[7:2], 2'h0})
      `REG_CONTROL: rd_val = {31'h0000_0000, st.ext_heads};
      `REG_STATUS: rd_val = 32'({st.cyl[st.seek_unit], 6'h00, st.floppy,
        1'h0, st.seek_unit, 1'h0, st.cmd_st == C_INIT,
        st.cmd_st == C_DATA, st.seek_st != S_IDLE});
      `REG_IRQ_STATUS: rd_val = {27'h000_0000, st.irq_stat};
      `REG_IRQ_ENABLE: rd_val = {27'h000_0000, st.irq_en};
      `REG_PARAM_SEL: rd_val = {25'h000_0000, st.param_sel};
      `REG_PARAM_DATA: begin
        if (st.param_sel[3:0] < 4'(`PARAM_BYTES)) begin
          rd_val = {24'h00_0000,
            st.params[st.param_sel[6:4]][st.param_sel[3:0]]};
        end
      end
      `REG_SEEK, `REG_IRQ_CLEAR: rd_val = 32'h0000_0000;
      default: rd_err = 1'b1;
    endcase
    if (st.rvalid && rready) begin
      next.rvalid = 1'b0;
    end
    if (arvalid && st.arready) begin
      next.rvalid = 1'b1;
      next.rdata = rd_val;
      next.rresp = rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    next.arready = !next.rvalid;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.params <= {8{`HD_DEFAULTS}};
    end else begin
      st <= next;
    end
  end

  assign host_ack = st.host_ack;
  assign step = st.step;
  assign step_dir = st.dir;
  assign reduce_write_current = st.rwc;
  assign irq = st.irq;
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;

endmodule : drive_parameter_setup

// ---- drive_parameter_setup_asserts.sv ----
`timescale 1ns/10ps
`include "drive_parameter_setup_consts.svh"
module drive_parameter_setup_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic host_req,
  input wire logic host_ack,
  input wire logic step,
  input wire logic step_dir,
  input wire logic irq
);
  localparam int W_UNIT = `STEP_WIDTH_UNIT_CYC;
  localparam int F_UNIT = `FLOPPY_WIDTH_UNIT_CYC;
  localparam int W_TOP = 255 * `FLOPPY_WIDTH_UNIT_CYC;
  logic [15:0] high_cnt;

  // cycles the current step pulse has been high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt <= 16'h0000;
    end else begin
      high_cnt <= step ? high_cnt + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence pulse_end_s;
    $fell(step);
  endsequence

  sequence req_drop_s;
    $fell(host_req) && host_ack;
  endsequence

  width_min_a: assert property (pulse_end_s |-> high_cnt >= W_UNIT)
    else $error("step pulse shorter than minimum width");
  width_grid_a: assert property (pulse_end_s |->
    (high_cnt % W_UNIT == 0 || high_cnt % F_UNIT == 0) && high_cnt <= W_TOP)
    else $error("step pulse width off grid or too long");
  gap_min_a: assert property (pulse_end_s |=> !step [*4])
    else $error("step gap too short");
  dir_hold_a: assert property (step && $past(step) |-> $stable(step_dir))
    else $error("direction changed during step pulse");
  ack_cause_a: assert property ($rose(host_ack) |-> $past(host_req, 2))
    else $error("byte ack without request");
  ack_hold_a: assert property (host_ack && host_req |=> host_ack)
    else $error("byte ack dropped while request held");
  ack_drop_a: assert property (req_drop_s |-> ##[1:4] !host_ack)
    else $error("byte ack not released");
  reset_idle_a: assert property ($rose(rst_n) |-> !step && !host_ack && !irq)
    else $error("outputs active right after reset");
endmodule : drive_parameter_setup_asserts

bind drive_parameter_setup drive_parameter_setup_asserts
  u_drive_parameter_setup_asserts (.clock(clock), .rst_n(rst_n),
  .host_req(host_req), .host_ack(host_ack), .step(step),
  .step_dir(step_dir), .irq(irq));

// ---- host_adapter.sv ----
`timescale 1ns/10ps
module host_adapter
  import drive_parameter_setup_pkg::*;
(
  input wire logic clock,
  input wire logic host_ack,
  output logic host_req,
  output logic host_cd,
  output logic [7:0] host_data
);
  initial begin
    host_req = 1'b0;
    host_cd = 1'b0;
    host_data = 8'h00;
  end

  // released lines show the inverse of the last value
  task automatic send_byte(input logic cd, input logic [7:0] d);
    host_data <= d;
    host_cd <= cd;
    @(posedge clock);
    host_req <= 1'b1;
    do @(posedge clock); while (host_ack !== 1'b1);
    host_req <= 1'b0;
    host_data <= ~d;
    host_cd <= ~cd;
    do @(posedge clock); while (host_ack !== 1'b0);
  endtask : send_byte

  task automatic send_cmd(input logic [7:0] op, input logic [2:0] unit);
    send_byte(1'b1, op);
    send_byte(1'b1, {unit, 5'h00});
    repeat (4) send_byte(1'b1, 8'h00);
  endtask : send_cmd

  task automatic send_params(input param_set_t p);
    for (int i = 0; i < 10; i++) send_byte(1'b0, p[i]);
  endtask : send_params
endmodule : host_adapter

// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "drive_parameter_setup_consts.svh"
module tb_top
  import drive_parameter_setup_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] floppy_switch = 2'b01;
  logic seek_complete = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic host_req, host_cd, host_ack, step, step_dir, rwc, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] host_data;
  logic [1:0] bresp, rresp, rs, bs;
  logic [31:0] rdata, rd;
  int error_cnt = 0;
  int comparisons = 0;
  int pulses = 0;
  param_set_t hd = `HD_DEFAULTS;
  param_set_t fl = `FLOPPY_DEFAULTS;
  param_set_t np = {8'h00, 8'h00, 8'h40, 8'h02, 8'h0A, 8'h00, 8'h03,
    8'h00, 8'h01, 8'h00};
  param_set_t xp = {8'h00, 8'h00, 8'h40, 8'h02, 8'h0A, 8'h00, 8'h0F,
    8'h00, 8'h01, 8'h00};

  drive_parameter_setup #(.STEP_PERIOD_CYC(5), .INTERVAL_CYC(20),
    .TIMEOUT_CYC(20000)) u_drive_parameter_setup (.clock(clock),
    .rst_n(rst_n), .host_req(host_req), .host_cd(host_cd),
    .host_data(host_data), .host_ack(host_ack),
    .floppy_switch(floppy_switch), .seek_complete(seek_complete),
    .step(step), .step_dir(step_dir), .reduce_write_current(rwc),
    .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));

  host_adapter u_host_adapter (.clock(clock), .host_ack(host_ack),
    .host_req(host_req), .host_cd(host_cd), .host_data(host_data));

  always #5 clock = ~clock;
  always @(posedge step) pulses++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bs = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask : rd_reg

  task automatic rdp(input logic [2:0] u, input int i, input logic [7:0] e);
    wr(`REG_PARAM_SEL, {25'h0, u, i[3:0]});
    rd_reg(`REG_PARAM_DATA);
    chk(rd, {24'h0, e});
  endtask : rdp

  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      rdp(3'd2, i, hd[i]);
      rdp(3'd0, i, fl[i]);
    end
    rd_reg(`REG_STATUS);
    chk(rd & 32'h300, 32'h100);
    $display("test defaults done");
    u_host_adapter.send_cmd(`SET_PARAMS_OPCODE, 3'd3);
    u_host_adapter.send_params(np);
    for (int i = 0; i < 10; i++) rdp(3'd3, i, np[i]);
    rdp(3'd2, 0, hd[0]);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`REG_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(`REG_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test load done");
    u_host_adapter.send_cmd(8'h01, 3'd3);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h2);
    rdp(3'd3, 0, np[0]);
    rd_reg(8'h40);
    chk(rd, 32'h0);
    chk({30'h0, rs}, 32'h2);
    wr(8'h40, 32'h0);
    chk({30'h0, bs}, 32'h2);
    $display("test reject done");
    wr(`REG_IRQ_CLEAR, 32'h1F);
    pulses = 0;
    wr(`REG_SEEK, 32'h0003_0003);
    chk({30'h0, bs}, 32'h0);
    do rd_reg(`REG_STATUS); while (rd[0] !== 1'b0);
    chk(pulses, 32'h3);
    chk(rd & 32'h03FF_0070, 32'h0003_0030);
    chk({31'h0, rwc}, 32'h1);
    chk({31'h0, step_dir}, 32'h1);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h4);
    $display("test fast seek done");
    u_host_adapter.send_cmd(`SET_PARAMS_OPCODE, 3'd0);
    u_host_adapter.send_params(fl);
    wr(`REG_IRQ_CLEAR, 32'h1F);
    pulses = 0;
    wr(`REG_SEEK, 32'h0002_0010);
    do rd_reg(`REG_STATUS); while (rd[0] !== 1'b0);
    chk(pulses, 32'h2);
    chk(rd & 32'h03FF_0070, 32'h0002_0000);
    chk({31'h0, rwc}, 32'h0);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h4);
    $display("test floppy seek done");
    wr(`REG_CONTROL, 32'h1);
    u_host_adapter.send_cmd(`SET_PARAMS_OPCODE, 3'd4);
    u_host_adapter.send_params(xp);
    wr(`REG_IRQ_CLEAR, 32'h1F);
    wr(`REG_SEEK, 32'h0000_0094);
    do rd_reg(`REG_STATUS); while (rd[0] !== 1'b0);
    chk({31'h0, rwc}, 32'h1);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h4);
    wr(`REG_IRQ_CLEAR, 32'h1F);
    wr(`REG_SEEK, 32'h0000_0043);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h10);
    wr(`REG_IRQ_CLEAR, 32'h1F);
    wr(`REG_SEEK, 32'h000B_0003);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h10);
    $display("test heads done");
    wr(`REG_IRQ_CLEAR, 32'h1F);
    wr(`REG_IRQ_ENABLE, 32'h8);
    pulses = 0;
    wr(`REG_SEEK, 32'h0001_0002);
    repeat (3000) @(posedge clock);
    rd_reg(`REG_STATUS);
    chk(rd & 32'h1, 32'h1);
    chk(pulses, 32'h1);
    do @(posedge clock); while (irq !== 1'b1);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd & 32'h8, 32'h8);
    chk({31'h0, rwc}, 32'h0);
    $display("test seek timeout done");
    seek_complete <= 1'b1;
    wr(`REG_IRQ_CLEAR, 32'h1F);
    wr(`REG_SEEK, 32'h0000_0002);
    do rd_reg(`REG_STATUS); while (rd[0] !== 1'b0);
    chk({31'h0, step_dir}, 32'h0);
    chk(rd & 32'h03FF_0000, 32'h0);
    rd_reg(`REG_IRQ_STATUS);
    chk(rd, 32'h4);
    $display("test seek complete done");
    test_done();
  end
endmodule : tb_top
